// ---- hw/row_prot_pkg.sv ----
package row_prot_pkg;

   localparam int ROW_AW    = 8;
   localparam int HROW_AW   = 6;
   localparam int FIELD_W   = 2;
   localparam int FIELDS_PB = 4;

   localparam logic [1:0] MODE_OPEN     = 2'h0;
   localparam logic [1:0] MODE_NO_READ  = 2'h1;
   localparam logic [1:0] MODE_NO_EXTWR = 2'h2;
   localparam logic [1:0] MODE_NO_INTWR = 2'h3;

   localparam logic [5:0] CODE_OK       = 6'h00;
   localparam logic [5:0] CODE_PROT_ERR = 6'h09;
   localparam int         CODE_LSB      = 2;
   localparam logic [1:0] STAT_DONE     = 2'h1;
   localparam logic [7:0] STAT_RESET    = 8'h00;
   localparam logic [7:0] BYTE_CLEAR    = 8'h00;

   typedef enum logic [2:0] {
      OP_CODE_FETCH = 3'h0,
      OP_DATA_FETCH = 3'h1,
      OP_READ_CMD   = 3'h2,
      OP_EXT_WRITE  = 3'h3,
      OP_INT_WRITE  = 3'h4,
      OP_ERASE_ROW  = 3'h5,
      OP_PROTECT    = 3'h6,
      OP_ERASE_ALL  = 3'h7
   } op_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LOOK  = 2'b01,
      ST_CHECK = 2'b11,
      ST_CLEAR = 2'b10
   } state_t;

   typedef struct packed {
      logic                op_valid;
      op_t                 op;
      logic                ext_src;
      logic [ROW_AW-1:0]   row;
      logic [7:0]          prot_byte;
   } cmd_t;

   typedef struct packed {
      logic                done;
      logic                allow;
      logic [7:0]          status;
   } result_t;

endpackage : row_prot_pkg

// ---- hw/prot_row_mem.sv ----
`timescale 1ns/100ps
module prot_row_mem
   import row_prot_pkg::*;
#(
   parameter int AW = HROW_AW
) (
   // Clock
   input  wire logic          clk_sys,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   // Read port
   input  wire logic [AW-1:0] rd_addr,
   output logic      [7:0]    rd_data
);
   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : prot_row_mem

// ---- hw/flash_row_protection_check.sv ----
`timescale 1ns/100ps
module flash_row_protection_check
   import row_prot_pkg::*;
#(
   parameter int RW = ROW_AW
) (
   // Clock and reset
   input  wire logic    clk_sys,
   input  wire logic    arst_n,
   // Command side
   input  wire cmd_t    cmd,
   // Result side
   output result_t      result,
   output logic         flash_go
);
   localparam int HAW       = RW - 2;
   localparam int NB        = 1 << HAW;
   localparam int ERASE_CYC = NB + 1;

   typedef struct packed {
      state_t           st;
      cmd_t             cur;
      logic [HAW-1:0]   ptr;
      logic             any_prot;
      result_t          res;
      logic             go;
   } core_t;

   core_t s_reg;
   core_t s_next;

   logic [7:0]     rd_byte;
   logic           mem_we;
   logic [HAW-1:0] mem_waddr;
   logic [7:0]     mem_wdata;
   logic [HAW-1:0] mem_raddr;
   logic [1:0]     field;
   logic           ok;
   logic [FIELD_W-1:0] row_fields [FIELDS_PB];

   // Mode permits the operation
   function automatic logic permit(input op_t op, input logic [1:0] m);
      case (op)
         OP_CODE_FETCH: permit = 1'b1;
         OP_DATA_FETCH,
         OP_READ_CMD:   permit = (m == MODE_OPEN);
         OP_EXT_WRITE:  permit = (m == MODE_OPEN) || (m == MODE_NO_READ);
         OP_INT_WRITE,
         OP_ERASE_ROW:  permit = (m != MODE_NO_INTWR);
         default:       permit = 1'b1;
      endcase
   endfunction : permit

   // Erase by an external source counts as external write
   function automatic op_t eff_op(input cmd_t c);
      eff_op = (c.op == OP_ERASE_ROW && c.ext_src) ? OP_EXT_WRITE : c.op;
   endfunction : eff_op

   prot_row_mem #(.AW(HAW)) u_mem (
      .clk_sys (clk_sys),
      .wr_en   (mem_we),
      .wr_addr (mem_waddr),
      .wr_data (mem_wdata),
      .rd_addr (mem_raddr),
      .rd_data (rd_byte)
   );

   assign mem_raddr = s_reg.cur.row[RW-1:2];
   for (genvar g = 0; g < FIELDS_PB; g++) begin : g_fields
      assign row_fields[g] = rd_byte[g*FIELD_W +: FIELD_W];
   end
   assign field     = row_fields[s_reg.cur.row[1:0]];
   assign ok        = permit(eff_op(s_reg.cur), field);

   always_comb begin
      s_next    = s_reg;
      s_next.res.done = 1'b0;
      s_next.go = 1'b0;
      mem_we    = 1'b0;
      mem_waddr = s_reg.ptr;
      mem_wdata = BYTE_CLEAR;
      case (s_reg.st)
         ST_IDLE: begin
            if (cmd.op_valid) begin
               s_next.cur = cmd;
               if (cmd.op == OP_ERASE_ALL) begin
                  s_next.ptr = '0;
                  s_next.st  = ST_CLEAR;
               end else if (cmd.op == OP_PROTECT) begin
                  s_next.res.done   = 1'b1;
                  s_next.res.allow  = !s_reg.any_prot;
                  s_next.res.status = {s_reg.any_prot ? CODE_PROT_ERR : CODE_OK,
                                       STAT_DONE};
                  if (!s_reg.any_prot) begin
                     mem_we    = 1'b1;
                     mem_waddr = cmd.row[RW-1:2];
                     mem_wdata = cmd.prot_byte;
                     s_next.any_prot = |cmd.prot_byte;
                  end
               end else begin
                  s_next.st = ST_LOOK;
               end
            end
         end
         ST_LOOK: begin
            s_next.st = ST_CHECK;
         end
         ST_CHECK: begin
            s_next.st         = ST_IDLE;
            s_next.res.done   = 1'b1;
            s_next.res.allow  = ok;
            s_next.go         = ok;
            s_next.res.status = {ok ? CODE_OK : CODE_PROT_ERR, STAT_DONE};
         end
         ST_CLEAR: begin
            mem_we     = 1'b1;
            s_next.ptr = s_reg.ptr + 1'b1;
            if (s_reg.ptr == HAW'(NB - 1)) begin
               s_next.st         = ST_IDLE;
               s_next.any_prot   = 1'b0;
               s_next.res.done   = 1'b1;
               s_next.res.allow  = 1'b1;
               s_next.go         = 1'b1;
               s_next.res.status = {CODE_OK, STAT_DONE};
            end
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign result   = s_reg.res;
   assign flash_go = s_reg.go;

   a_refuse_code: assert property (@(posedge clk_sys) disable iff (!arst_n)
      result.done && !result.allow |-> result.status[7:CODE_LSB] == CODE_PROT_ERR)
      else $error("refusal without code 09");

   a_refuse_nogo: assert property (@(posedge clk_sys) disable iff (!arst_n)
      result.done && !result.allow |-> !flash_go)
      else $error("refused op reached flash");

   sequence s_take;
      s_reg.st == ST_IDLE && cmd.op_valid && cmd.op != OP_ERASE_ALL
         && cmd.op != OP_PROTECT;
   endsequence

   a_check_time: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_take |-> ##3 result.done)
      else $error("check not done in three cycles");

   a_code_fetch: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_take ##0 (cmd.op == OP_CODE_FETCH) |-> ##3 result.allow)
      else $error("code fetch refused");

   a_mode_open: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_reg.st == ST_CHECK && field == MODE_OPEN |-> ##1 result.allow)
      else $error("open row refused");

   a_mode_noread: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_reg.st == ST_CHECK && field != MODE_OPEN && (s_reg.cur.op == OP_DATA_FETCH
         || s_reg.cur.op == OP_READ_CMD) |-> ##1 !result.allow)
      else $error("protected read allowed");

   a_mode_intwr: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_reg.st == ST_CHECK && s_reg.cur.op == OP_INT_WRITE
         |-> ##1 result.allow == (field != MODE_NO_INTWR))
      else $error("internal write decision wrong");

   a_protect_gate: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_reg.st == ST_IDLE && cmd.op_valid && cmd.op == OP_PROTECT && s_reg.any_prot
         |-> ##1 result.done && !result.allow)
      else $error("protect accepted while protected");

   a_erase_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_reg.st == ST_CLEAR |-> mem_we && mem_wdata == BYTE_CLEAR)
      else $error("erase all skipped a byte");

   sequence s_checked;
      s_reg.st == ST_CHECK;
   endsequence

   sequence s_protect_take;
      s_reg.st == ST_IDLE && cmd.op_valid && cmd.op == OP_PROTECT;
   endsequence

   sequence s_erase_take;
      s_reg.st == ST_IDLE && cmd.op_valid && cmd.op == OP_ERASE_ALL;
   endsequence

   a_go_allowed: assert property (@(posedge clk_sys) disable iff (!arst_n)
      flash_go |-> result.done && result.allow)
      else $error("flash started without an allowed result");

   a_go_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
      flash_go |=> !flash_go)
      else $error("flash start longer than one cycle");

   a_ok_status: assert property (@(posedge clk_sys) disable iff (!arst_n)
      result.done && result.allow |-> result.status[7:CODE_LSB] == CODE_OK)
      else $error("allowed op without success code");

   a_status_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
      result.done |-> result.status[CODE_LSB-1:0] == STAT_DONE)
      else $error("status low bits wrong at done");

   a_busy_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_reg.st == ST_LOOK || s_reg.st == ST_CHECK |-> !result.done && !flash_go)
      else $error("result before the check");

   a_busy_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_reg.st != ST_IDLE |=> s_reg.cur == $past(s_reg.cur))
      else $error("request taken while busy");

   a_fetch_open: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_checked ##0 (s_reg.cur.op == OP_CODE_FETCH) |-> ##1 result.allow && flash_go)
      else $error("code fetch not started");

   a_read_open: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_checked ##0 (field == MODE_OPEN && (s_reg.cur.op == OP_DATA_FETCH
         || s_reg.cur.op == OP_READ_CMD)) |-> ##1 result.allow && flash_go)
      else $error("open read not started");

   a_extwr_open: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_checked ##0 (field < MODE_NO_EXTWR && (s_reg.cur.op == OP_EXT_WRITE
         || s_reg.cur.op == OP_ERASE_ROW && s_reg.cur.ext_src)) |-> ##1 result.allow)
      else $error("external write refused on open row");

   a_extwr_shut: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_checked ##0 (field >= MODE_NO_EXTWR && (s_reg.cur.op == OP_EXT_WRITE
         || s_reg.cur.op == OP_ERASE_ROW && s_reg.cur.ext_src)) |-> ##1 !result.allow)
      else $error("external write allowed on shut row");

   a_int_erase: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_checked ##0 (s_reg.cur.op == OP_ERASE_ROW && !s_reg.cur.ext_src
         && field != MODE_NO_INTWR) |-> ##1 result.allow)
      else $error("internal erase refused");

   a_mode_locked: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_checked ##0 (field == MODE_NO_INTWR && s_reg.cur.op != OP_CODE_FETCH)
         |-> ##1 !result.allow)
      else $error("locked row allowed an access");

   a_protect_ok: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_protect_take ##0 !s_reg.any_prot |-> ##1 result.done && result.allow && !flash_go)
      else $error("protect refused while unprotected");

   a_protect_lock: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_protect_take ##0 (!s_reg.any_prot && cmd.prot_byte != BYTE_CLEAR)
         |=> s_reg.any_prot)
      else $error("protection not recorded");

   a_protect_nowr: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_protect_take ##0 s_reg.any_prot |-> !mem_we)
      else $error("refused protect wrote the hidden row");

   a_protect_quick: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_protect_take |=> s_reg.st == ST_IDLE)
      else $error("protect did not finish in one cycle");

   a_erase_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_erase_take |=> s_reg.st == ST_CLEAR && s_reg.ptr == '0)
      else $error("erase all did not start at byte zero");

   a_erase_walk: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_reg.st == ST_CLEAR && s_reg.ptr != HAW'(NB - 1)
         |=> s_reg.st == ST_CLEAR && s_reg.ptr == $past(s_reg.ptr) + 1'b1)
      else $error("erase all skipped ahead");

   a_erase_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_reg.st == ST_CLEAR |-> !result.done && !flash_go)
      else $error("result during erase all");

   a_erase_time: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_erase_take |-> ##ERASE_CYC result.done && result.allow && flash_go)
      else $error("erase all not done in time");

   a_erase_unlock: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_erase_take |-> ##ERASE_CYC !s_reg.any_prot)
      else $error("erase all left protection set");

endmodule : flash_row_protection_check

// ---- verification/cmd_agent.sv ----
`timescale 1ns/100ps
module cmd_agent
   import row_prot_pkg::*;
(
   // Clock
   input  wire logic    clk_sys,
   // From block
   input  wire result_t result,
   input  wire logic    flash_go,
   // To block
   output cmd_t         cmd
);
   initial cmd = '0;

   // One-cycle request, then fields scrambled so stale values never look valid
   task automatic issue(input op_t op, input logic ext, input logic [7:0] row,
                        input logic [7:0] pb, output result_t res, output logic go);
      logic got;
      res = '0;
      go  = 1'b0;
      got = 1'b0;
      @(negedge clk_sys);
      cmd <= '{1'b1, op, ext, row, pb};
      // A protect answers right after the edge that takes it
      @(posedge clk_sys);
      #1;
      if (result.done === 1'b1) begin
         got = 1'b1;
         res = result;
         go  = flash_go;
      end
      @(negedge clk_sys);
      cmd <= cmd_t'({1'b0, ~op, ~ext, ~row, ~pb});
      for (int n = 0; n < 200 && !got; n++) begin
         @(posedge clk_sys);
         #1;
         if (result.done === 1'b1) begin
            got = 1'b1;
            res = result;
            go  = flash_go;
         end
      end
   endtask : issue
endmodule : cmd_agent

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
module testbench
   import row_prot_pkg::*;
();
   logic    clk_sys;
   logic    arst_n;
   cmd_t    cmd;
   result_t result;
   logic    flash_go;
   int      fail_count;
   int      checks_done;

   flash_row_protection_check dut (.clk_sys(clk_sys), .arst_n(arst_n), .cmd(cmd),
                                   .result(result), .flash_go(flash_go));
   cmd_agent agent (.clk_sys(clk_sys), .result(result), .flash_go(flash_go), .cmd(cmd));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      if (fail_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   function automatic logic exp_allow(input op_t op, input logic ext, input logic [1:0] m);
      case (op)
         OP_DATA_FETCH, OP_READ_CMD: return m == MODE_OPEN;
         OP_EXT_WRITE:               return m < MODE_NO_EXTWR;
         OP_INT_WRITE:               return m < MODE_NO_INTWR;
         OP_ERASE_ROW:               return ext ? m < MODE_NO_EXTWR : m < MODE_NO_INTWR;
         default:                    return 1'b1;
      endcase
   endfunction : exp_allow

   task automatic run_op(input op_t op, input logic ext, input logic [7:0] row,
                         input logic [7:0] pb, input logic ok);
      result_t r;
      logic    go;
      agent.issue(op, ext, row, pb, r, go);
      check("done", {7'h00, r.done}, 8'h01);
      check("allow", {7'h00, r.allow}, {7'h00, ok});
      check("status", r.status, {ok ? CODE_OK : CODE_PROT_ERR, STAT_DONE});
      check("flash_go", {7'h00, go}, {7'h00, ok & (op != OP_PROTECT)});
   endtask : run_op

   // Rows 4..7 get modes 00,01,10,11 through byte 1
   task automatic scen_protect();
      run_op(OP_ERASE_ALL, 1'b0, 8'h00, 8'h00, 1'b1);
      run_op(OP_PROTECT, 1'b0, 8'h04, 8'hE4, 1'b1);
   endtask : scen_protect

   task automatic scen_modes();
      op_t op;
      for (int m = 0; m < 4; m++) begin
         for (int o = 0; o < 7; o++) begin
            op = (o < 6) ? op_t'(o) : OP_ERASE_ROW;
            run_op(op, o == 6, 8'(4 + m), 8'h00, exp_allow(op, o == 6, 2'(m)));
         end
      end
      run_op(OP_DATA_FETCH, 1'b0, 8'h00, 8'h00, 1'b1);
   endtask : scen_modes

   task automatic scen_refuse_protect();
      run_op(OP_PROTECT, 1'b0, 8'h00, 8'hFF, 1'b0);
      run_op(OP_READ_CMD, 1'b0, 8'h01, 8'h00, 1'b1);
   endtask : scen_refuse_protect

   task automatic scen_erase_clears();
      run_op(OP_ERASE_ALL, 1'b0, 8'h00, 8'h00, 1'b1);
      run_op(OP_INT_WRITE, 1'b0, 8'h07, 8'h00, 1'b1);
      run_op(OP_PROTECT, 1'b0, 8'h00, 8'h40, 1'b1);
      run_op(OP_READ_CMD, 1'b0, 8'h03, 8'h00, 1'b0);
   endtask : scen_erase_clears

   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      complete_run();
   end

   initial begin
      fail_count  = 0;
      checks_done = 0;
      arst_n      = 1'b0;
      repeat (2) @(negedge clk_sys);
      arst_n = 1'b1;
      scen_protect();
      scen_modes();
      scen_refuse_protect();
      scen_erase_clears();
      complete_run();
   end
endmodule : testbench
